/* irq_prio_pkg.sv */
// Package: register offsets, bit positions, reset values and source indices of the interrupt block
package irq_prio_pkg;
    // Register offsets on the plain register port
    localparam logic [7:0] PRIORITY_SELECT_LOW_OFS = 8'hA9;
    localparam logic [7:0] PRIORITY_SELECT_HIGH_OFS = 8'hB9;
    localparam logic [7:0] COMPARE_TIMER_CONTROL_OFS = 8'hE1;
    localparam logic [7:0] REQ_FLAGS_OFS = 8'hC0;
    localparam logic [7:0] STD_FLAGS_OFS = 8'hC1;
    localparam logic [7:0] ENABLE_A_OFS = 8'hC2;
    localparam logic [7:0] ENABLE_B_OFS = 8'hC3;
    localparam logic [7:0] MODE_CTRL_OFS = 8'hC4;
    localparam logic [7:0] SVC_STATUS_OFS = 8'hC5;
    localparam logic [7:0] EVT_STATUS_OFS = 8'hC6;
    localparam logic [7:0] EVT_CLEAR_OFS = 8'hC7;
    localparam logic [7:0] EVT_ENABLE_OFS = 8'hC8;
    // Bit positions in the converter/external flag register
    localparam int REQ_CONV_BIT = 0;
    localparam int REQ_EXT2_BIT = 1;
    localparam int REQ_T2OVF_BIT = 6;
    localparam int REQ_T2RLD_BIT = 7;
    // Bit positions in the standard flag register
    localparam int STD_EXT0_BIT = 0;
    localparam int STD_EXT1_BIT = 1;
    localparam int STD_T0_BIT = 2;
    localparam int STD_T1_BIT = 3;
    localparam int STD_S0_BIT = 4;
    localparam int STD_S1_BIT = 5;
    // Mode control bits, then the compare timer flag bit and the group count
    localparam int MODE_EXT0_EDGE_BIT = 0;
    localparam int MODE_EXT1_EDGE_BIT = 1;
    localparam int MODE_EXT2_RISE_BIT = 2;
    localparam int MODE_EXT3_RISE_BIT = 3;
    localparam int MODE_T2_RELOAD_EN_BIT = 4;
    localparam int MODE_GLOBAL_DIS_BIT = 7;
    localparam int CT_FLAG_BIT = 3;
    localparam int GROUP_BITS = 6;
    // Reset values
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] EN_A_RESET = 8'h00;
    // Source indices in poll order: group g holds sources 3g, 3g+1, 3g+2
    localparam int NUM_SLOTS = 18;
    localparam int NUM_SRC = 14;
    localparam logic [4:0] SRC_NONE = 5'h1F;
    // Vector addresses per slot, zero where the slot is empty
    localparam logic [15:0] VECTORS [NUM_SLOTS] = '{
        16'h0003, 16'h0083, 16'h0043,
        16'h000B, 16'h0000, 16'h004B,
        16'h0013, 16'h0000, 16'h0053,
        16'h001B, 16'h009B, 16'h005B,
        16'h0023, 16'h0000, 16'h0063,
        16'h002B, 16'h0000, 16'h006B
    };
    localparam logic [NUM_SLOTS-1:0] SLOT_USED = 18'h3FEDB ^ 18'h0E4C9 ^ 18'h0E4C9;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_VECTOR = 3'b010,
        ST_WAIT = 3'b100
    } ack_state_e;
endpackage : irq_prio_pkg

/* irq_prio_ctrl.sv */
// Request flags, enables, four-level priority arbitration and vector request
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Converter flag set at conversion end, software clears
// - Ext 2..6 flags: edge or compare, auto-clear
// - Compare 4,0,1,2,3 set flags 2..6
// - Timer 2 overflow flag, software clear only
// - Reload flag set on falling edge when enabled
// - Timer 2 request is OR of both flags
// - Compare timer flag, hardware clears on vectoring
// - Software writes set or clear any flag except level-mode ext0/1
// - Level mode ext0/1 flags follow the pin
// - Per-source enables plus global disable bit
// - Six groups of pairs and triplets share level
// - Level from both registers, high register MSB
// - Preempt only by strictly higher level
// - Highest level among simultaneous requests wins first
// - Equal level: earlier group, then earlier member wins
// - Fixed order never causes preemption
// - Priority registers use bits 0..5 at addresses
// - Taking a request loads fixed vector per source
module irq_prio_ctrl
    import irq_prio_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Event inputs, one-cycle pulses, and pins
    input wire logic i_conv_done,
    input wire logic [6:2] i_ext_pin,
    input wire logic [4:0] i_compare_evt,
    input wire logic i_timer2_ovf,
    input wire logic i_timer2_reload_pin,
    input wire logic i_cmp_timer_ovf,
    input wire logic i_timer0_ovf,
    input wire logic i_timer1_ovf,
    input wire logic i_ext0_pin,
    input wire logic i_ext1_pin,
    input wire logic i_serial0_req,
    input wire logic i_serial1_req,
    // CPU core handshake
    input wire logic i_vec_ack,
    input wire logic i_reti,
    output logic o_vec_req,
    output logic [15:0] o_vec_addr,
    output logic [1:0] o_active_level,
    // Event interrupt
    output logic o_irq
);
    logic [7:0] req_q, std_q, en_a_q, en_b_q, mode_q, prio_lo_q, prio_hi_q, compare_timer_control_q;
    logic [7:0] evt_q, evt_en_q;
    logic [6:2] ext_pin_q;
    logic t2_pin_q, ext0_pin_q, ext1_pin_q;
    logic [3:0] in_svc_q;
    logic [4:0] slot_q;
    logic [15:0] vec_q;
    ack_state_e state_q;

    // Write decode
    wire wr_req = i_wr && i_addr == REQ_FLAGS_OFS;
    wire wr_std = i_wr && i_addr == STD_FLAGS_OFS;
    wire wr_ct = i_wr && i_addr == COMPARE_TIMER_CONTROL_OFS;
    wire wr_evt_clr = i_wr && i_addr == EVT_CLEAR_OFS;

    // Edge detection on sampled pins; mode bits pick the active edge of ext2 and ext3
    wire [6:2] rise = i_ext_pin & ~ext_pin_q;
    wire [6:2] fall = ~i_ext_pin & ext_pin_q;
    wire ext2_edge = mode_q[MODE_EXT2_RISE_BIT] ? rise[2] : fall[2];
    wire ext3_edge = mode_q[MODE_EXT3_RISE_BIT] ? rise[3] : fall[3];
    wire [6:2] ext_set = {rise[6], rise[5], rise[4], ext3_edge, ext2_edge}
        | {i_compare_evt[3], i_compare_evt[2], i_compare_evt[1], i_compare_evt[0],
           i_compare_evt[4]};
    wire t2_reload_set = ~i_timer2_reload_pin & t2_pin_q
        & mode_q[MODE_T2_RELOAD_EN_BIT];
    wire ext0_fall = ~i_ext0_pin & ext0_pin_q;
    wire ext1_fall = ~i_ext1_pin & ext1_pin_q;
    wire ext0_edge_mode = mode_q[MODE_EXT0_EDGE_BIT];
    wire ext1_edge_mode = mode_q[MODE_EXT1_EDGE_BIT];

    // Requests by slot; level-mode ext0/1 are the inverted pin directly
    wire ext0_req = ext0_edge_mode ? std_q[STD_EXT0_BIT] : ~i_ext0_pin;
    wire ext1_req = ext1_edge_mode ? std_q[STD_EXT1_BIT] : ~i_ext1_pin;
    wire t2_req = req_q[REQ_T2OVF_BIT] | req_q[REQ_T2RLD_BIT];
    wire [NUM_SLOTS-1:0] raw_req = {
        req_q[5], 1'b0, t2_req,
        req_q[4], 1'b0, std_q[STD_S0_BIT] | i_serial0_req,
        req_q[3], compare_timer_control_q[CT_FLAG_BIT], std_q[STD_T1_BIT],
        req_q[2], 1'b0, ext1_req,
        req_q[1], 1'b0, std_q[STD_T0_BIT],
        req_q[REQ_CONV_BIT], std_q[STD_S1_BIT] | i_serial1_req, ext0_req};
    // Enables: en_a bits 0..7, en_b bits 0..5 in the same slot order, unused slots skipped
    wire [NUM_SRC-1:0] src_en = {en_b_q[5:0], en_a_q[7:0]};
    wire [NUM_SLOTS-1:0] slot_en = {src_en[13], 1'b0, src_en[12],
        src_en[11], 1'b0, src_en[10], src_en[9:7], src_en[6], 1'b0, src_en[5],
        src_en[4], 1'b0, src_en[3], src_en[2:0]};
    wire global_off = mode_q[MODE_GLOBAL_DIS_BIT];
    wire [NUM_SLOTS-1:0] pend = raw_req & slot_en & {NUM_SLOTS{~global_off}};

    // Arbitration: best level first, then lowest slot index
    logic [4:0] win_slot;
    logic [1:0] win_lvl;
    logic win_found;
    always_comb begin
        win_slot = SRC_NONE;
        win_lvl = 2'h0;
        win_found = 1'b0;
        for (int i = 0; i < NUM_SLOTS; i++) begin
            if (pend[i] && (!win_found
                || {prio_hi_q[i/3], prio_lo_q[i/3]} > win_lvl)) begin
                win_found = 1'b1;
                win_lvl = {prio_hi_q[i/3], prio_lo_q[i/3]};
                win_slot = 5'(i);
            end
        end
    end
    // Highest level now in service
    logic [1:0] cur_lvl;
    logic any_svc;
    always_comb begin
        cur_lvl = 2'h0;
        any_svc = |in_svc_q;
        for (int l = 0; l < 4; l++) begin
            if (in_svc_q[l]) begin
                cur_lvl = 2'(l);
            end
        end
    end
    // Strictly higher level only, so the within-level order never preempts
    wire can_take = win_found && (!any_svc || win_lvl > cur_lvl);
    wire take = state_q == ST_IDLE && can_take;
    wire ack = state_q == ST_VECTOR && i_vec_ack;
    wire [1:0] take_lvl = {prio_hi_q[slot_q/3], prio_lo_q[slot_q/3]};
    wire [NUM_SLOTS-1:0] ack_clr = ack ? (NUM_SLOTS'(1) << slot_q) : '0;

    // Flag updates: hardware set wins over a same-cycle clear
    wire [7:0] req_d = ((wr_req ? i_wdata : req_q)
        & ~{1'b0, 1'b0, ack_clr[17], ack_clr[14], ack_clr[11], ack_clr[8], ack_clr[5], 1'b0})
        | {t2_reload_set, i_timer2_ovf, ext_set, i_conv_done};
    wire [7:0] std_wr = wr_std ? i_wdata : std_q;
    wire [7:0] std_d = {2'b00,
        std_wr[STD_S1_BIT], std_wr[STD_S0_BIT],
        (std_wr[STD_T1_BIT] & ~ack_clr[9]) | i_timer1_ovf,
        (std_wr[STD_T0_BIT] & ~ack_clr[3]) | i_timer0_ovf,
        ext1_edge_mode ? ((std_wr[STD_EXT1_BIT] & ~ack_clr[6]) | ext1_fall)
            : ~i_ext1_pin,
        ext0_edge_mode ? ((std_wr[STD_EXT0_BIT] & ~ack_clr[0]) | ext0_fall)
            : ~i_ext0_pin};
    wire ct_d = ((wr_ct ? i_wdata[CT_FLAG_BIT] : compare_timer_control_q[CT_FLAG_BIT]) & ~ack_clr[10])
        | i_cmp_timer_ovf;
    wire [7:0] evt_now = {4'h0, ack, take, i_reti & any_svc, 1'b0};
    wire [7:0] evt_d = (evt_q & ~(wr_evt_clr ? i_wdata : 8'h00)) | evt_now;

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            req_q <= REG_RESET;
            std_q <= REG_RESET;
            compare_timer_control_q <= REG_RESET;
            evt_q <= REG_RESET;
            // Matches each pin's idle level (ext2..6 low, reload and ext0/1 high), so release of reset makes no false edge
            ext_pin_q <= '0;
            t2_pin_q <= 1'b1;
            ext0_pin_q <= 1'b1;
            ext1_pin_q <= 1'b1;
        end else begin
            req_q <= req_d;
            std_q <= std_d;
            compare_timer_control_q <= {compare_timer_control_q[7:4], ct_d, compare_timer_control_q[2:0]};
            evt_q <= evt_d;
            ext_pin_q <= i_ext_pin;
            t2_pin_q <= i_timer2_reload_pin;
            ext0_pin_q <= i_ext0_pin;
            ext1_pin_q <= i_ext1_pin;
            if (wr_ct) begin
                compare_timer_control_q[7:4] <= i_wdata[7:4];
                compare_timer_control_q[2:0] <= i_wdata[2:0];
            end
        end
    end

    // Configuration registers
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            en_a_q <= EN_A_RESET;
            en_b_q <= REG_RESET;
            mode_q <= REG_RESET;
            prio_lo_q <= REG_RESET;
            prio_hi_q <= REG_RESET;
            evt_en_q <= REG_RESET;
        end else if (i_wr) begin
            if (i_addr == ENABLE_A_OFS) en_a_q <= i_wdata;
            if (i_addr == ENABLE_B_OFS) en_b_q <= {2'b00, i_wdata[5:0]};
            if (i_addr == MODE_CTRL_OFS) mode_q <= i_wdata;
            if (i_addr == PRIORITY_SELECT_LOW_OFS) prio_lo_q <= i_wdata;
            if (i_addr == PRIORITY_SELECT_HIGH_OFS) prio_hi_q <= {2'b00, i_wdata[5:0]};
            if (i_addr == EVT_ENABLE_OFS) evt_en_q <= i_wdata;
        end
    end

    // Vector request sequencer and in-service levels
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            state_q <= ST_IDLE;
            slot_q <= SRC_NONE;
            vec_q <= 16'h0000;
            in_svc_q <= 4'h0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (take) begin
                        state_q <= ST_VECTOR;
                        slot_q <= win_slot;
                        vec_q <= VECTORS[win_slot];
                    end
                end
                ST_VECTOR: begin
                    if (i_vec_ack) begin
                        state_q <= ST_WAIT;
                        in_svc_q[take_lvl] <= 1'b1;
                    end
                end
                ST_WAIT: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
            if (i_reti && state_q != ST_VECTOR) begin
                in_svc_q[cur_lvl] <= 1'b0;
            end
        end
    end

    // Read mux, data one cycle after the strobe
    logic [7:0] rd_mux;
    always_comb begin
        case (i_addr)
            REQ_FLAGS_OFS: rd_mux = req_q;
            STD_FLAGS_OFS: rd_mux = std_q;
            ENABLE_A_OFS: rd_mux = en_a_q;
            ENABLE_B_OFS: rd_mux = en_b_q;
            MODE_CTRL_OFS: rd_mux = mode_q;
            PRIORITY_SELECT_LOW_OFS: rd_mux = prio_lo_q;
            PRIORITY_SELECT_HIGH_OFS: rd_mux = prio_hi_q;
            COMPARE_TIMER_CONTROL_OFS: rd_mux = compare_timer_control_q;
            SVC_STATUS_OFS: rd_mux = {4'h0, in_svc_q};
            EVT_STATUS_OFS: rd_mux = evt_q;
            EVT_ENABLE_OFS: rd_mux = evt_en_q;
            default: rd_mux = 8'h00;
        endcase
    end
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= i_rd ? rd_mux : 8'h00;
        end
    end

    assign o_vec_req = state_q == ST_VECTOR;
    assign o_vec_addr = vec_q;
    assign o_active_level = cur_lvl;
    assign o_irq = |(evt_q & evt_en_q);

    // Checks
    conv_set_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        i_conv_done |=> req_q[REQ_CONV_BIT]) else $error("converter flag not set");
    cmp_map_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        i_compare_evt[4] |=> req_q[REQ_EXT2_BIT]) else $error("compare 4 lost");
    auto_clr_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        ack && slot_q == 5'd5 && !ext_set[2] |=> !req_q[REQ_EXT2_BIT])
        else $error("ext2 not cleared");
    t2_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        req_q[REQ_T2OVF_BIT] && !wr_req |=> req_q[REQ_T2OVF_BIT])
        else $error("timer2 flag lost");
    reload_set_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        t2_reload_set |=> req_q[REQ_T2RLD_BIT]) else $error("reload flag not set");
    global_off_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        global_off |-> !take) else $error("request while disabled");
    // Checked against the raw in-service bits, not the derived current level
    no_preempt_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        take |-> (in_svc_q >> win_lvl) == 4'h0) else $error("equal level preempt");
    vec_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        o_vec_req && !i_vec_ack |=> o_vec_req && $stable(o_vec_addr))
        else $error("vector dropped");
    c_take: cover property (@(posedge i_ref_clk) take);
    c_nest: cover property (@(posedge i_ref_clk) take && any_svc);
    c_irq: cover property (@(posedge i_ref_clk) o_irq);
endmodule : irq_prio_ctrl
`default_nettype wire

/* cpu_core_model.sv */
// CPU core stand-in: takes each vector request after a settable delay
`timescale 1ns/1ns
`default_nettype none
module cpu_core_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Vector handshake
    input wire logic i_req,
    input wire logic [15:0] i_addr,
    input wire logic [3:0] i_delay,
    output logic o_ack
);
    logic [15:0] got [$];
    logic [3:0] wait_q;
    // Ack stands one cycle; a long delay stretches the request phase
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_ack <= 1'b0;
            wait_q <= 4'h0;
        end else if (i_req && !o_ack && wait_q >= i_delay) begin
            o_ack <= 1'b1;
            wait_q <= 4'h0;
            got.push_back(i_addr);
        end else begin
            o_ack <= 1'b0;
            wait_q <= i_req ? wait_q + 4'h1 : 4'h0;
        end
    end
endmodule : cpu_core_model
`default_nettype wire

/* tb_irq_prio_ctrl.sv */
// Self-checking bench for the interrupt flag and priority block
`timescale 1ns/1ns
`default_nettype none
module tb_irq_prio_ctrl
    import irq_prio_pkg::*;
;
    logic clk, rst, wr, rd, conv, t2o, ctov, t0o, t1o, p0_n, p1_n, s0, s1, ack, reti, rl_pin;
    logic vreq, irq;
    logic [7:0] addr, wd, rdat, d, r, lo, hi;
    logic [6:2] pins;
    logic [4:0] cmp;
    logic [15:0] vaddr;
    logic [1:0] alvl;
    logic [3:0] dly;
    logic [17:0] pend;
    int n_fail, comparisons, cyc, seed, w, lvl [6];
    // Poll order slot 3g+k: vector, flag register and bit of each source
    logic [15:0] vt [18] = '{16'h0003, 16'h0083, 16'h0043, 16'h000B, 16'h0000, 16'h004B,
        16'h0013, 16'h0000, 16'h0053, 16'h001B, 16'h009B, 16'h005B,
        16'h0023, 16'h0000, 16'h0063, 16'h002B, 16'h0000, 16'h006B};
    logic [7:0] freg [18] = '{8'hC1, 8'hC1, 8'hC0, 8'hC1, 8'h00, 8'hC0, 8'hC1, 8'h00, 8'hC0,
        8'hC1, 8'hE1, 8'hC0, 8'hC1, 8'h00, 8'hC0, 8'hC0, 8'h00, 8'hC0};
    int fbit [18] = '{0, 5, 0, 2, 0, 1, 1, 0, 2, 3, 3, 3, 4, 0, 4, 6, 0, 5};
    logic [7:0] ra [9] = '{8'hA9, 8'hB9, REQ_FLAGS_OFS, 8'hC1, 8'hC2, 8'hC3, 8'hC4, 8'hE1, 8'h10};
    logic [9:0] fm [7] = '{10'h020, 10'h040, 10'h080, 10'h100, 10'h200, 10'h010, 10'h008};
    logic [7:0] cm [7] = '{8'h04, 8'h08, 8'h10, 8'h20, 8'h02, 8'h01, 8'h40};

    irq_prio_ctrl DUT (.i_ref_clk(clk), .i_reset(rst), .i_addr(addr), .i_wdata(wd),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdat), .i_conv_done(conv), .i_ext_pin(pins),
        .i_compare_evt(cmp), .i_timer2_ovf(t2o), .i_timer2_reload_pin(rl_pin),
        .i_cmp_timer_ovf(ctov), .i_timer0_ovf(t0o), .i_timer1_ovf(t1o), .i_ext0_pin(p0_n),
        .i_ext1_pin(p1_n), .i_serial0_req(s0), .i_serial1_req(s1), .i_vec_ack(ack),
        .i_reti(reti), .o_vec_req(vreq), .o_vec_addr(vaddr), .o_active_level(alvl),
        .o_irq(irq));
    cpu_core_model core (.i_clk(clk), .i_reset(rst), .i_req(vreq), .i_addr(vaddr),
        .i_delay(dly), .o_ack(ack));

    task automatic tally(input logic ok);
        comparisons++;
        if (!ok) begin
            n_fail++;
            $display("MISMATCH %0t compare failed", $time);
        end
    endtask : tally
    task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
        tally(g === e);
    endtask : chk_reg
    task automatic chk_vec(input logic [15:0] g, input logic [15:0] e);
        tally(g === e);
    endtask : chk_vec
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wd <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdat;
    endtask : rd_reg
    task automatic fire(input logic [9:0] m);
        @(posedge clk);
        {cmp, conv, t2o, ctov, t0o, t1o} <= m;
        @(posedge clk);
        {cmp, conv, t2o, ctov, t0o, t1o} <= 10'h000;
    endtask : fire
    task automatic ret;
        @(posedge clk);
        reti <= 1'b1;
        @(posedge clk);
        reti <= 1'b0;
    endtask : ret
    task automatic exp_vec(input logic [15:0] v);
        repeat (60) if (core.got.size() == 0) @(posedge clk);
        if (core.got.size() == 0) tally(1'b0);
        else chk_vec(core.got.pop_front(), v);
        repeat (2) @(posedge clk);
    endtask : exp_vec
    task automatic no_vec;
        repeat (20) @(posedge clk);
        tally(vreq === 1'b0 && core.got.size() == 0);
    endtask : no_vec
    task automatic svc(input logic [15:0] v, input logic [7:0] a, input logic [7:0] e);
        exp_vec(v);
        rd_reg(a);
        chk_reg(d, e);
        wr_reg(a, 8'h00);
        ret;
    endtask : svc
    // Reference arbiter: highest level, then earliest slot in poll order
    function automatic int win(input logic [17:0] p);
        int b;
        b = -1;
        for (int s = 0; s < 18; s++)
            if (p[s] && (b < 0 || lvl[s / 3] > lvl[b / 3])) b = s;
        return b;
    endfunction : win
    function automatic logic [7:0] rv(input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        for (int s = 0; s < 18; s++)
            if (pend[s] && freg[s] == a) v[fbit[s]] = 1'b1;
        return v;
    endfunction : rv
    task automatic complete_run;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : complete_run

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Whole run needs under two thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            n_fail++;
            complete_run;
        end
    end

    initial begin
        {wr, rd, conv, t2o, ctov, t0o, t1o, s0, s1, reti, cmp, pins} = '0;
        {p0_n, p1_n, rl_pin, rst} = 4'hF;
        {addr, wd, dly} = 20'h00000;
        seed = 19;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        foreach (ra[i]) begin
            rd_reg(ra[i]);
            chk_reg(d, 8'h00);
        end
        for (int i = 0; i < 2; i++) begin
            r = 8'($random(seed));
            wr_reg(ra[i], r);
            rd_reg(ra[i]);
            chk_reg(d & 8'h3F, r & 8'h3F);
            wr_reg(ra[i], 8'h00);
        end
        foreach (fm[i]) begin
            wr_reg(8'hC0, 8'h00);
            fire(fm[i]);
            rd_reg(8'hC0);
            chk_reg(d, cm[i]);
        end
        fire(10'h004);
        rd_reg(8'hE1);
        chk_reg(d & 8'h08, 8'h08);
        wr_reg(8'hC0, 8'h00);
        pins[4] <= 1'b1;
        rd_reg(8'hC0);
        pins[4] <= 1'b0;
        chk_reg(d, 8'h08);
        for (int e = 0; e < 2; e++) begin
            wr_reg(8'hC0, 8'h00);
            wr_reg(8'hC4, e ? 8'h10 : 8'h00);
            rl_pin <= 1'b0;
            rd_reg(8'hC0);
            rl_pin <= 1'b1;
            rd_reg(8'hC0);
            chk_reg(d, e ? 8'h80 : 8'h00);
        end
        r = 8'($random(seed));
        wr_reg(8'hC0, r);
        rd_reg(8'hC0);
        chk_reg(d, r);
        wr_reg(8'hC0, 8'h00);
        wr_reg(8'hE1, 8'h00);
        wr_reg(8'hC2, 8'hFF);
        wr_reg(8'hC3, 8'h3F);
        fire(10'h010);
        svc(16'h0043, 8'hC0, 8'h01);
        fire(10'h040);
        svc(16'h005B, 8'hC0, 8'h00);
        fire(10'h008);
        svc(16'h002B, 8'hC0, 8'h40);
        wr_reg(8'hC0, 8'h80);
        svc(16'h002B, 8'hC0, 8'h80);
        fire(10'h004);
        svc(16'h009B, 8'hE1, 8'h00);
        fire(10'h002);
        svc(16'h000B, 8'hC1, 8'h00);
        fire(10'h001);
        svc(16'h001B, 8'hC1, 8'h00);
        s0 <= 1'b1;
        exp_vec(16'h0023);
        s0 <= 1'b0;
        ret;
        s1 <= 1'b1;
        exp_vec(16'h0083);
        s1 <= 1'b0;
        ret;
        wr_reg(8'hC1, 8'h01);
        rd_reg(8'hC1);
        chk_reg(d & 8'h01, 8'h00);
        p0_n <= 1'b0;
        rd_reg(8'hC1);
        chk_reg(d & 8'h01, 8'h01);
        exp_vec(16'h0003);
        p0_n <= 1'b1;
        ret;
        // Rising mode on ext3 and falling-edge mode on ext0
        wr_reg(8'hC4, 8'h1D);
        pins[3] <= 1'b1;
        svc(16'h0053, 8'hC0, 8'h00);
        pins[3] <= 1'b0;
        p0_n <= 1'b0;
        svc(16'h0003, 8'hC1, 8'h00);
        p0_n <= 1'b1;
        wr_reg(8'hC4, 8'h90);
        wr_reg(8'hC0, 8'h01);
        no_vec;
        wr_reg(8'hC2, 8'hFB);
        wr_reg(8'hC4, 8'h10);
        no_vec;
        wr_reg(8'hC2, 8'hFF);
        svc(16'h0043, 8'hC0, 8'h01);
        wr_reg(8'hA9, 8'h21);
        wr_reg(8'hB9, 8'h02);
        wr_reg(8'hC0, 8'h20);
        exp_vec(16'h006B);
        chk_reg({6'h00, alvl}, 8'h01);
        wr_reg(8'hC0, 8'h01);
        no_vec;
        wr_reg(8'hC0, 8'h03);
        exp_vec(16'h004B);
        chk_reg({6'h00, alvl}, 8'h02);
        ret;
        no_vec;
        ret;
        svc(16'h0043, 8'hC0, 8'h01);
        // Random levels, all fourteen sources pending at once, slow and prompt core
        repeat (3) begin
            dly <= 4'($random(seed) & 7);
            for (int g = 0; g < 6; g++) begin
                lvl[g] = $random(seed) & 3;
                lo[g] = lvl[g][0];
                hi[g] = lvl[g][1];
            end
            wr_reg(8'hC4, 8'h93);
            wr_reg(8'hA9, lo & 8'h3F);
            wr_reg(8'hB9, hi & 8'h3F);
            pend = 18'h2DF6F;
            wr_reg(8'hC0, rv(8'hC0));
            wr_reg(8'hC1, rv(8'hC1));
            wr_reg(8'hE1, rv(8'hE1));
            wr_reg(8'hC4, 8'h13);
            repeat (14) begin
                w = win(pend);
                exp_vec(vt[w]);
                chk_reg({6'h00, alvl}, 8'(lvl[w / 3]));
                pend[w] = 1'b0;
                wr_reg(freg[w], rv(freg[w]));
                ret;
            end
        end
        rd_reg(8'hC6);
        chk_reg(d & 8'h0E, 8'h0E);
        chk_reg({7'h00, irq}, 8'h00);
        wr_reg(8'hC8, 8'h08);
        repeat (2) @(posedge clk);
        chk_reg({7'h00, irq}, 8'h01);
        wr_reg(8'hC7, 8'h08);
        repeat (2) @(posedge clk);
        chk_reg({7'h00, irq}, 8'h00);
        complete_run;
    end
endmodule : tb_irq_prio_ctrl
`default_nettype wire
